// File: hw/audio_mute_input_select.sv
// Mute input source selectors for the second and third audio ports.
// Assumes pins are asynchronous to mclk; register port is on mclk.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps

module audio_mute_input_select #(
  parameter bit third_port_present = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic serial_data_pin_7,
  input wire logic serial_data_pin_8,
  input wire logic serial_data_pin_9,
  input wire logic third_port_rx_high_freq_clock,
  input wire logic first_spi_slave_in_pin,
  input wire logic first_spi_chip_select_pin,
  input wire logic first_spi_enable_pin,
  output logic port1_mute_in,
  output logic port2_mute_in
);

  // ****************************************
  // Source multiplexer
  // ****************************************
  function automatic logic pick_source(input logic [2:0] sel, input logic [6:0] src);
    logic r;
    r = 1'b0;
    unique case (sel)
      mute_sel_pkg::SRC_ZERO: r = 1'b0;
      mute_sel_pkg::SRC_SD7: r = src[mute_sel_pkg::PIN_SD7];
      mute_sel_pkg::SRC_SD8: r = src[mute_sel_pkg::PIN_SD8];
      mute_sel_pkg::SRC_SD9: r = src[mute_sel_pkg::PIN_SD9];
      mute_sel_pkg::SRC_AHCLK: r = src[mute_sel_pkg::PIN_AHCLK];
      mute_sel_pkg::SRC_SPI0_SI: r = src[mute_sel_pkg::PIN_SPI0_SI];
      mute_sel_pkg::SRC_SPI0_CS: r = src[mute_sel_pkg::PIN_SPI0_CS];
      mute_sel_pkg::SRC_SPI0_EN: r = src[mute_sel_pkg::PIN_SPI0_EN];
    endcase
    return r;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Sampling the high-frequency clock at mclk aliases; it only suits a slow level
  logic [6:0] pins;
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;

  assign pins = {first_spi_enable_pin, first_spi_chip_select_pin, first_spi_slave_in_pin,
                 third_port_rx_high_freq_clock, serial_data_pin_9, serial_data_pin_8,
                 serial_data_pin_7};

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end
    else if (clk_en)
    begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  // ****************************************
  // Selector registers and read port
  // ****************************************
  logic [2:0] sel1_q;
  logic [2:0] sel1_d;
  logic [2:0] sel2_q;
  logic [2:0] sel2_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic hit1;
  logic hit2;

  always_comb
  begin
    hit1 = reg_addr == mute_sel_pkg::PORT1_SEL_ADDR;
    // Absent third port: decode misses, so writes drop and reads return zero
    hit2 = third_port_present && (reg_addr == mute_sel_pkg::PORT2_SEL_ADDR);
    sel1_d = sel1_q;
    sel2_d = sel2_q;
    rdata_d = mute_sel_pkg::RDATA_IDLE;
    if (reg_wr && hit1)
    begin
      sel1_d = reg_wdata[mute_sel_pkg::SEL_MSB:mute_sel_pkg::SEL_LSB];
    end
    if (reg_wr && hit2)
    begin
      sel2_d = reg_wdata[mute_sel_pkg::SEL_MSB:mute_sel_pkg::SEL_LSB];
    end
    // Reserved bits read zero; upper write data is ignored
    if (reg_rd && hit1)
    begin
      rdata_d[mute_sel_pkg::SEL_MSB:mute_sel_pkg::SEL_LSB] = sel1_q;
    end
    if (reg_rd && hit2)
    begin
      rdata_d[mute_sel_pkg::SEL_MSB:mute_sel_pkg::SEL_LSB] = sel2_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel1_q <= mute_sel_pkg::SEL_RESET;
      sel2_q <= mute_sel_pkg::SEL_RESET;
      rdata_q <= mute_sel_pkg::RDATA_IDLE;
    end
    else if (clk_en)
    begin
      sel1_q <= sel1_d;
      sel2_q <= sel2_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ****************************************
  // Mute outputs
  // ****************************************
  logic mute1_q;
  logic mute1_d;
  logic mute2_q;
  logic mute2_d;

  always_comb
  begin
    mute1_d = pick_source(sel1_q, sync2_q);
    mute2_d = third_port_present ? pick_source(sel2_q, sync2_q) : 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mute1_q <= 1'b0;
      mute2_q <= 1'b0;
    end
    else if (clk_en)
    begin
      mute1_q <= mute1_d;
      mute2_q <= mute2_d;
    end
  end

  assign port1_mute_in = mute1_q;
  assign port2_mute_in = mute2_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sel1_write_a: assert property (clk_en && reg_wr && hit1 |=> sel1_q == $past(reg_wdata[2:0]))
    else $error("port1 selector did not take write");

  sel2_write_a: assert property (clk_en && reg_wr && hit2 |=> sel2_q == $past(reg_wdata[2:0]))
    else $error("port2 selector did not take write");

  sel1_readback_a: assert property (clk_en && reg_rd && hit1 |=> reg_rdata == {29'h0, $past(sel1_q)})
    else $error("port1 selector read back wrong");

  sel2_readback_a: assert property (clk_en && reg_rd && hit2 |=> reg_rdata == {29'h0, $past(sel2_q)})
    else $error("port2 selector read back wrong");

  // Frozen cycles must not move the stored selector
  frozen_sel_a: assert property (!clk_en |=> sel1_q == $past(sel1_q))
    else $error("selector moved with clock enable low");

  zero_source_a: assert property (clk_en && sel1_q == mute_sel_pkg::SRC_ZERO |=> !port1_mute_in)
    else $error("code zero did not give zero");

  pin7_route_a: assert property (clk_en && sel1_q == mute_sel_pkg::SRC_SD7
                                 |=> port1_mute_in == $past(sync2_q[mute_sel_pkg::PIN_SD7]))
    else $error("serial data 7 not routed");

  clock_route_a: assert property (clk_en && sel2_q == mute_sel_pkg::SRC_AHCLK
                                  |=> port2_mute_in == $past(sync2_q[mute_sel_pkg::PIN_AHCLK]))
    else $error("high frequency clock not routed");

  slave_in_route_a: assert property (clk_en && sel1_q == mute_sel_pkg::SRC_SPI0_SI
                                     |=> port1_mute_in == $past(sync2_q[mute_sel_pkg::PIN_SPI0_SI]))
    else $error("SPI0 slave-in pin not routed");

  select_route_a: assert property (clk_en && sel2_q == mute_sel_pkg::SRC_SPI0_CS
                                   |=> port2_mute_in == $past(sync2_q[mute_sel_pkg::PIN_SPI0_CS]))
    else $error("SPI0 chip select pin not routed");

  enable_route_a: assert property (clk_en && sel1_q == mute_sel_pkg::SRC_SPI0_EN
                                   |=> port1_mute_in == $past(sync2_q[mute_sel_pkg::PIN_SPI0_EN]))
    else $error("SPI0 enable pin not routed");

  reserved_zero_a: assert property (clk_en && reg_rd |=> reg_rdata[31:3] == 29'h0)
    else $error("reserved read bits not zero");

  absent_port_a: assert property (!third_port_present |-> sel2_q == 3'h0 && !port2_mute_in)
    else $error("absent third port not inert");

  write_to_mute_a: assert property (clk_en && reg_wr && hit1 && reg_wdata[2:0] == mute_sel_pkg::SRC_ZERO
                                    ##1 clk_en |=> !port1_mute_in)
    else $error("new setting not applied promptly");

  write1_c: cover property (clk_en && reg_wr && hit1);
  read2_c: cover property (clk_en && reg_rd && hit2);
  mute_rise_c: cover property (clk_en && !port1_mute_in ##1 port1_mute_in);
  frozen_write_c: cover property (!clk_en && reg_wr);

endmodule

// File: hw/mute_sel_pkg.sv
// Constants for the audio mute input source selectors.
// Assumes a 32-bit register port with byte addresses.
package mute_sel_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [31:0] PORT1_SEL_ADDR = 32'h4000_001C;
  localparam logic [31:0] PORT2_SEL_ADDR = 32'h4000_0020;

  // ****************************************
  // Selector field
  // ****************************************
  localparam int SEL_W = 3;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 2;
  localparam int RSVD_LSB = 3;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

  // ****************************************
  // Source codes
  // ****************************************
  localparam logic [2:0] SRC_ZERO = 3'h0;
  localparam logic [2:0] SRC_SD7 = 3'h1;
  localparam logic [2:0] SRC_SD8 = 3'h2;
  localparam logic [2:0] SRC_SD9 = 3'h3;
  localparam logic [2:0] SRC_AHCLK = 3'h4;
  localparam logic [2:0] SRC_SPI0_SI = 3'h5;
  localparam logic [2:0] SRC_SPI0_CS = 3'h6;
  localparam logic [2:0] SRC_SPI0_EN = 3'h7;

  // Bit positions in the synchronised source vector
  localparam int PIN_SD7 = 0;
  localparam int PIN_SD8 = 1;
  localparam int PIN_SD9 = 2;
  localparam int PIN_AHCLK = 3;
  localparam int PIN_SPI0_SI = 4;
  localparam int PIN_SPI0_CS = 5;
  localparam int PIN_SPI0_EN = 6;
  localparam int PIN_N = 7;

endpackage

// File: verif/mute_detect_model.sv
// Far-side model: the two audio ports' mute detectors.
// Assumes mute levels arrive as registered levels on mclk.
`timescale 1ns/100ps
module mute_detect_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic mute_a,
  input wire logic mute_b,
  output logic [1:0] muted_q
);
  logic [1:0] muted_d;
  always_comb
  begin
    muted_d = {mute_b, mute_a};
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      muted_q <= 2'h0;
    else
      muted_q <= muted_d;
  end
endmodule

// File: verif/audio_mute_input_select_tb.sv
// Register-port tests of the mute source selectors.
// Assumes one 20 MHz clock; a second instance models the two-port variant.
`timescale 1ns/100ps
module audio_mute_input_select_tb;
  localparam logic [31:0] P1 = mute_sel_pkg::PORT1_SEL_ADDR;
  localparam logic [31:0] P2 = mute_sel_pkg::PORT2_SEL_ADDR;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic clk_en = 1'b1;
  logic [6:0] pins = 7'h00;
  logic [6:0] mask;
  logic [31:0] rdata_a, rdata_b, ra, rb;
  logic mute_a, mute_b, mute_c;
  logic [1:0] muted_q;
  int failures = 0;
  int checks = 0;
  audio_mute_input_select dut_u (.mclk, .rst_b, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata(rdata_a), .serial_data_pin_7(pins[0]), .serial_data_pin_8(pins[1]), .serial_data_pin_9(pins[2]),
    .third_port_rx_high_freq_clock(pins[3]), .first_spi_slave_in_pin(pins[4]),
    .first_spi_chip_select_pin(pins[5]), .first_spi_enable_pin(pins[6]),
    .port1_mute_in(mute_a), .port2_mute_in(mute_b));
  audio_mute_input_select #(.third_port_present(1'b0)) dut_b (.mclk, .rst_b, .clk_en, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rdata_b), .serial_data_pin_7(pins[0]),
    .serial_data_pin_8(pins[1]), .serial_data_pin_9(pins[2]), .third_port_rx_high_freq_clock(pins[3]),
    .first_spi_slave_in_pin(pins[4]), .first_spi_chip_select_pin(pins[5]), .first_spi_enable_pin(pins[6]),
    .port1_mute_in(), .port2_mute_in(mute_c));
  mute_detect_model far_u (.mclk, .rst_b, .mute_a, .mute_b, .muted_q);
  initial
  begin
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    ra = rdata_a;
    rb = rdata_b;
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #(3000 * 50);
    failures++;
    close_out();
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    rd(P1);
    chk("port1 reset", 32'h0, ra);
    rd(P2);
    chk("port2 reset", 32'h0, ra);
    chk("absent port2", 32'h0, rb);
    $display("test reset done");
    // Upper bits written as zero, so every code appears on both ports
    for (int c = 0; c < 8; c++)
    begin
      wr(P1, 32'(c));
      wr(P2, 32'(7 - c));
      rd(P1);
      chk("port1 sel", 32'(c), ra);
      rd(P2);
      chk("port2 sel", 32'(7 - c), ra);
      chk("absent sel", 32'h0, rb);
      mask = (c == 0) ? 7'h7F : 7'(7'h01 << (c - 1));
      @(posedge mclk);
      pins <= mask;
      // Two sync stages, output flop and model flop; sample off the edge
      repeat (6) @(posedge mclk);
      #1;
      chk("port1 mute on", 32'(c != 0), {31'h0, muted_q[0]});
      chk("port2 mute on", 32'(c == 0), {31'h0, muted_q[1]});
      @(posedge mclk);
      pins <= ~mask;
      repeat (6) @(posedge mclk);
      #1;
      chk("port1 mute off", 32'h0, {31'h0, muted_q[0]});
      // Last pass leaves port2 on code zero, which forces zero
      chk("port2 mute off", 32'(c != 0 && c != 7), {31'h0, muted_q[1]});
      chk("absent mute", 32'h0, {31'h0, mute_c});
    end
    $display("test codes done");
    wr(32'h4000_0018, 32'h0000_0005);
    // Write with the clock enable low must be dropped
    @(posedge mclk);
    clk_en <= 1'b0;
    wr(P1, 32'h0000_0002);
    clk_en <= 1'b1;
    rd(P1);
    chk("port1 kept", 32'h0000_0007, ra);
    rd(32'h4000_0018);
    chk("unmapped read", 32'h0, ra);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rd(P1);
    chk("port1 rereset", 32'h0, ra);
    repeat (4) @(posedge mclk);
    #1;
    chk("mute rereset", 32'h0, {30'h0, muted_q});
    $display("test unmapped and reset done");
    close_out();
  end
endmodule
